// >>> logic/scs_defs.vh
// constants for the serial command source selector
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SCS_OFF_ADDR      12'h000
`define SCS_OFF_BAUD      12'h004
`define SCS_OFF_PROTO     12'h008
`define SCS_OFF_SEL       12'h00C
`define SCS_OFF_CTRL      12'h010
`define SCS_OFF_STATUS    12'h014
// ----------------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------------
`define SCS_SEL_COAST_LSB 0
`define SCS_SEL_BRAKE_LSB 2
`define SCS_SEL_START_LSB 4
`define SCS_SEL_REV_LSB   6
`define SCS_CW_STOP_BIT   3
`define SCS_CW_START_BIT  6
`define SCS_CW_REV_BIT    15
`define SCS_SRC_TERM      2'h0
`define SCS_SRC_SERIAL    2'h1
`define SCS_SRC_AND       2'h2
`define SCS_SRC_OR        2'h3
`define SCS_BAUD_300      3'h0
`define SCS_BAUD_4800     3'h4
`define SCS_BAUD_9600     3'h5
`define SCS_PROTO_NATIVE  2'h0
`define SCS_PROTO_BAS     2'h1
`define SCS_PROTO_FLN     2'h2
`define SCS_PROTO_RTU     2'h3
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SCS_RST_ADDR      8'h01
`define SCS_RST_BAUD      3'h5
`define SCS_RST_PROTO     2'h0
`define SCS_RST_SEL       8'h0F
`define SCS_RST_CW        16'h0000
`endif

// >>> logic/scs_sync3.v
// three-stage input synchroniser with second/third agreement
`timescale 1ns/1ps
module scs_sync3 (
  input  wire pclk,
  input  wire presetn,
  input  wire rst_val,
  input  wire pin,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg lvl_q;
  // stages hold the pin relative to its idle level, so a constant zero
  // reset still means idle and no false request follows reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin ^ rst_val;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts once stages two and three agree
      if (s2_q == s3_q)
        lvl_q <= s3_q;
    end
  end
  always @*
  begin
    level_q = lvl_q ^ rst_val;
  end
endmodule // scs_sync3

// >>> logic/scs_gate.v
// one command source gate: terminal, serial, and, or
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_gate (
  input  wire [1:0] sel,
  input  wire       term,
  input  wire       ser,
  input  wire       act_low,
  output wire       active
);
  wire t_act;
  wire s_act;
  reg  r;
  // convert to request-active polarity first so and/or mean request logic
  assign t_act = act_low ? ~term : term;
  assign s_act = act_low ? ~ser : ser;
  always @*
  begin
    case (sel)
      `SCS_SRC_TERM:   r = t_act;
      `SCS_SRC_SERIAL: r = s_act;
      `SCS_SRC_AND:    r = t_act & s_act;
      default:         r = t_act | s_act;
    endcase
  end
  assign active = r;
endmodule // scs_gate

// >>> logic/scs_core.v
// serial port settings and command source gating with an apb slave
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        panel_wr,
  input  wire [1:0]  panel_sel,
  input  wire [7:0]  panel_data,
  input  wire        factory_init,
  input  wire        coast_terminal_input,
  input  wire        brake_terminal_input,
  input  wire        start_terminal_input,
  input  wire        reverse_terminal_input,
  output reg         coast_q,
  output reg         brake_q,
  output reg         start_q,
  output reg         reverse_q,
  output reg  [7:0]  node_addr_q,
  output reg  [2:0]  baud_code_q,
  output reg         rate_ok_q
);
  // --------------------------------------------------------------------------
  // panel selections
  // --------------------------------------------------------------------------
  localparam [1:0] PNL_ADDR  = 2'h0;
  localparam [1:0] PNL_BAUD  = 2'h1;
  localparam [1:0] PNL_PROTO = 2'h2;

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  function rate_allowed;
    input [1:0] proto;
    input [2:0] baud;
    begin
      if (baud > `SCS_BAUD_9600)
        rate_allowed = 1'b0;
      else
      begin
        case (proto)
          `SCS_PROTO_BAS: rate_allowed = (baud == `SCS_BAUD_9600);
          `SCS_PROTO_FLN: rate_allowed = (baud >= `SCS_BAUD_4800);
          default:        rate_allowed = 1'b1;
        endcase
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg  [1:0]  proto_q;
  reg  [7:0]  sel_q;
  reg  [15:0] cw_q;
  wire        wr_en;
  wire        rd_en;
  wire        hit;
  wire        coast_t;
  wire        brake_t;
  wire        start_t;
  wire        rev_t;
  wire        coast_d;
  wire        brake_d;
  wire        start_d;
  wire        reverse_d;

  assign pready  = 1'b1;
  assign hit     = (paddr == `SCS_OFF_ADDR) || (paddr == `SCS_OFF_BAUD) ||
                   (paddr == `SCS_OFF_PROTO) || (paddr == `SCS_OFF_SEL) ||
                   (paddr == `SCS_OFF_CTRL) || (paddr == `SCS_OFF_STATUS);
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit;
  assign rd_en   = psel & ~penable & ~pwrite;

  // --------------------------------------------------------------------------
  // settings: address and baud only from the panel
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      node_addr_q <= `SCS_RST_ADDR;
      baud_code_q <= `SCS_RST_BAUD;
      proto_q     <= `SCS_RST_PROTO;
      sel_q       <= `SCS_RST_SEL;
      cw_q        <= `SCS_RST_CW;
    end
    else if (factory_init)
    begin
      node_addr_q <= `SCS_RST_ADDR;
      baud_code_q <= `SCS_RST_BAUD;
      proto_q     <= `SCS_RST_PROTO;
      sel_q       <= `SCS_RST_SEL;
      cw_q        <= `SCS_RST_CW;
    end
    else
    begin
      // bus writes to address and baud fall through unstored
      if (panel_wr && panel_sel == PNL_ADDR)
        node_addr_q <= panel_data;
      if (panel_wr && panel_sel == PNL_BAUD && panel_data[7:3] == 5'h00 &&
          panel_data[2:0] <= `SCS_BAUD_9600)
        baud_code_q <= panel_data[2:0];
      if (panel_wr && panel_sel == PNL_PROTO)
        proto_q <= panel_data[1:0];
      else if (wr_en && paddr == `SCS_OFF_PROTO)
        proto_q <= pwdata[1:0];
      if (wr_en && paddr == `SCS_OFF_SEL)
        sel_q <= pwdata[7:0];
      if (wr_en && paddr == `SCS_OFF_CTRL)
        cw_q <= pwdata[15:0];
    end
  end

  // --------------------------------------------------------------------------
  // read data, registered in the setup phase
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en)
    begin
      case (paddr)
        `SCS_OFF_ADDR:   prdata <= {24'h000000, node_addr_q};
        `SCS_OFF_BAUD:   prdata <= {29'h00000000, baud_code_q};
        `SCS_OFF_PROTO:  prdata <= {30'h00000000, proto_q};
        `SCS_OFF_SEL:    prdata <= {24'h000000, sel_q};
        `SCS_OFF_CTRL:   prdata <= {16'h0000, cw_q};
        `SCS_OFF_STATUS: prdata <= {27'h0000000, rate_ok_q, reverse_q, start_q,
                                    brake_q, coast_q};
        default:         prdata <= 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // terminal synchronisers
  // --------------------------------------------------------------------------
  scs_sync3 u_sync_coast (
    .pclk    (pclk),
    .presetn (presetn),
    .rst_val (1'b1),
    .pin     (coast_terminal_input),
    .level_q (coast_t)
  );
  scs_sync3 u_sync_brake (
    .pclk    (pclk),
    .presetn (presetn),
    .rst_val (1'b1),
    .pin     (brake_terminal_input),
    .level_q (brake_t)
  );
  scs_sync3 u_sync_start (
    .pclk    (pclk),
    .presetn (presetn),
    .rst_val (1'b0),
    .pin     (start_terminal_input),
    .level_q (start_t)
  );
  scs_sync3 u_sync_rev (
    .pclk    (pclk),
    .presetn (presetn),
    .rst_val (1'b0),
    .pin     (reverse_terminal_input),
    .level_q (rev_t)
  );

  // --------------------------------------------------------------------------
  // command gates
  // --------------------------------------------------------------------------
  // coast and brake are active low on both sources
  scs_gate u_gate_coast (
    .sel     (sel_q[`SCS_SEL_COAST_LSB+1:`SCS_SEL_COAST_LSB]),
    .term    (coast_t),
    .ser     (cw_q[`SCS_CW_STOP_BIT]),
    .act_low (1'b1),
    .active  (coast_d)
  );
  scs_gate u_gate_brake (
    .sel     (sel_q[`SCS_SEL_BRAKE_LSB+1:`SCS_SEL_BRAKE_LSB]),
    .term    (brake_t),
    .ser     (cw_q[`SCS_CW_STOP_BIT]),
    .act_low (1'b1),
    .active  (brake_d)
  );
  scs_gate u_gate_start (
    .sel     (sel_q[`SCS_SEL_START_LSB+1:`SCS_SEL_START_LSB]),
    .term    (start_t),
    .ser     (cw_q[`SCS_CW_START_BIT]),
    .act_low (1'b0),
    .active  (start_d)
  );
  scs_gate u_gate_rev (
    .sel     (sel_q[`SCS_SEL_REV_LSB+1:`SCS_SEL_REV_LSB]),
    .term    (rev_t),
    .ser     (cw_q[`SCS_CW_REV_BIT]),
    .act_low (1'b0),
    .active  (reverse_d)
  );

  // --------------------------------------------------------------------------
  // registered outputs keep selector changes glitch free
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      coast_q   <= 1'b0;
      brake_q   <= 1'b0;
      start_q   <= 1'b0;
      reverse_q <= 1'b0;
      rate_ok_q <= 1'b1;
    end
    else
    begin
      coast_q   <= coast_d;
      brake_q   <= brake_d;
      start_q   <= start_d;
      reverse_q <= reverse_d;
      rate_ok_q <= rate_allowed(proto_q, baud_code_q);
    end
  end
endmodule // scs_core

// >>> tb/scs_core_asserts.sv
// port-level assertions for the command source selector
`timescale 1ns/1ps
module scs_core_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pslverr,
  input wire        panel_wr,
  input wire [1:0]  panel_sel,
  input wire [7:0]  panel_data,
  input wire        factory_init,
  input wire [7:0]  node_addr_q,
  input wire [2:0]  baud_code_q
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  // a panel write or factory load in the same cycle may move the setting
  wire bwr = acc && pwrite && !panel_wr && !factory_init;
  wire pw  = panel_wr && !factory_init;
  property p_map; acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h014); endproperty
  property p_alock; bwr && paddr == 12'h000 |=> $stable(node_addr_q); endproperty
  property p_block; bwr && paddr == 12'h004 |=> $stable(baud_code_q); endproperty
  property p_brst; $rose(presetn) |-> baud_code_q == 3'h5; endproperty
  property p_fact; factory_init && !panel_wr |=> baud_code_q == 3'h5; endproperty
  property p_padr; pw && panel_sel == 2'h0 |=> node_addr_q == $past(panel_data); endproperty
  property p_pbad; pw && panel_sel == 2'h1 && panel_data > 8'h05 |=> $stable(baud_code_q);
  endproperty
  property p_pok; pw && panel_sel == 2'h1 && panel_data < 8'h06
    |=> {5'h00, baud_code_q} == $past(panel_data); endproperty
  a_map: assert property (p_map) else $error("pslverr wrong for address");
  a_alock: assert property (p_alock) else $error("bus changed node address");
  a_block: assert property (p_block) else $error("bus changed baud code");
  a_brst: assert property (p_brst) else $error("baud code not 5 after reset");
  a_fact: assert property (p_fact) else $error("factory load missed baud");
  a_padr: assert property (p_padr) else $error("panel address not stored");
  a_pbad: assert property (p_pbad) else $error("illegal baud code taken");
  a_pok: assert property (p_pok) else $error("panel baud not stored");
  c_block: cover property (bwr && paddr == 12'h004);
  c_pbad: cover property (pw && panel_sel == 2'h1 && panel_data > 8'h05);
  c_umap: cover property (acc && paddr > 12'h014);
endmodule // scs_core_asserts

bind scs_core scs_core_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pslverr, .panel_wr, .panel_sel, .panel_data, .factory_init, .node_addr_q, .baud_code_q);

// >>> tb/scs_term_model.sv
// model of the local input terminals wired to the drive pins
`timescale 1ns/1ps
module scs_term_model (
  input  wire       pclk,
  input  wire [3:0] req,
  output reg        coast_pin_n = 1'b1,
  output reg        brake_pin_n = 1'b1,
  output reg        start_pin   = 1'b0,
  output reg        rev_pin     = 1'b0
);
  // ----------------------------------------------------------------------
  // pins change on the clock edge only, like a scanned contact bank
  // ----------------------------------------------------------------------
  always @(posedge pclk)
  begin
    coast_pin_n <= ~req[3];
    brake_pin_n <= ~req[2];
    start_pin   <= req[1];
    rev_pin     <= req[0];
  end
endmodule // scs_term_model

// >>> tb/scs_core_tb.sv
// self-checking bench for the command source selector
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_core_tb;
  reg         pclk, presetn, psel, penable, pwrite, panel_wr, factory_init, er;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [1:0]  panel_sel;
  reg  [7:0]  panel_data;
  reg  [3:0]  term_req;
  wire [31:0] prdata;
  wire        pready, pslverr, cpn, bpn, spin, rpin;
  wire        coast_q, brake_q, start_q, reverse_q, rate_ok_q;
  wire [7:0]  node_addr_q;
  wire [2:0]  baud_code_q;
  integer     n_fail, cmp_count;
  // ----------------------------------------------------------------------
  // instances and shared tasks
  // ----------------------------------------------------------------------
  scs_term_model u_term (.pclk(pclk), .req(term_req), .coast_pin_n(cpn),
    .brake_pin_n(bpn), .start_pin(spin), .rev_pin(rpin));
  scs_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .panel_wr(panel_wr), .panel_sel(panel_sel), .panel_data(panel_data),
    .factory_init(factory_init), .coast_terminal_input(cpn), .brake_terminal_input(bpn),
    .start_terminal_input(spin), .reverse_terminal_input(rpin), .coast_q(coast_q),
    .brake_q(brake_q), .start_q(start_q), .reverse_q(reverse_q),
    .node_addr_q(node_addr_q), .baud_code_q(baud_code_q), .rate_ok_q(rate_ok_q));
  task tally_and_finish;
    begin
      if (n_fail == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // master holds the request until pready is seen high at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 10)
      begin
        i = i + 1;
        @(posedge pclk);
      end
      if (i == 10)
      begin
        n_fail = n_fail + 1;
        tally_and_finish;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task panel(input [1:0] s, input [7:0] d);
    begin
      @(posedge pclk);
      panel_wr <= 1'b1;
      panel_sel <= s;
      panel_data <= d;
      @(posedge pclk);
      panel_wr <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_reset_locks;
    begin
      apb(1'b0, `SCS_OFF_SEL, 32'h0);
      check("sel brake", rd[3:2], 2'h3);
      check("sel rev", rd[7:6], 2'h0);
      apb(1'b1, `SCS_OFF_ADDR, 32'h55);
      apb(1'b1, `SCS_OFF_BAUD, 32'h2);
      apb(1'b0, `SCS_OFF_ADDR, 32'h0);
      check("addr", rd, 32'h1);
      apb(1'b0, `SCS_OFF_BAUD, 32'h0);
      check("baud", rd, 32'h5);
      apb(1'b0, 12'h018, 32'h0);
      check("unmapped err", er, 1'b1);
    end
  endtask
  task t_panel_rate;
    begin
      panel(2'h0, 8'h2A);
      check("panel addr", node_addr_q, 8'h2A);
      panel(2'h1, 8'h04);
      panel(2'h1, 8'h06);
      check("panel baud", baud_code_q, 3'h4);
      apb(1'b1, `SCS_OFF_PROTO, 32'h1);
      repeat (2) @(posedge pclk);
      check("n2 at 4800", rate_ok_q, 1'b0);
      apb(1'b1, `SCS_OFF_PROTO, 32'h2);
      repeat (2) @(posedge pclk);
      check("fln at 4800", rate_ok_q, 1'b1);
      panel(2'h1, 8'h03);
      check("fln at 2400", rate_ok_q, 1'b0);
      factory_init <= 1'b1;
      repeat (2) @(posedge pclk);
      factory_init <= 1'b0;
      @(posedge pclk);
      check("factory baud", baud_code_q, 3'h5);
    end
  endtask
  // all four functions share one code; k[1] is the terminal request, k[0] the serial one
  task t_gate;
    integer c, k;
    reg     e;
    begin
      for (c = 0; c < 4; c = c + 1)
      begin
        apb(1'b1, `SCS_OFF_SEL, {24'h0, {4{c[1:0]}}});
        for (k = 0; k < 4; k = k + 1)
        begin
          term_req <= {4{k[1]}};
          apb(1'b1, `SCS_OFF_CTRL, k[0] ? 32'h8040 : 32'h0008);
          repeat (8) @(posedge pclk);
          e = c == 0 ? k[1] : c == 1 ? k[0] : c == 2 ? k[1] & k[0] : k[1] | k[0];
          check("coast", coast_q, e);
          check("brake", brake_q, e);
          check("start", start_q, e);
          check("reverse", reverse_q, e);
          apb(1'b0, `SCS_OFF_STATUS, 32'h0);
          check("status cmds", rd[3:0], {4{e}});
        end
      end
    end
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, panel_wr, factory_init} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    panel_sel = 2'h0;
    panel_data = 8'h00;
    term_req = 4'h0;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_locks;
    t_panel_rate;
    t_gate;
    tally_and_finish;
  end
endmodule // scs_core_tb
